//--- pkg/rom_patch_pkg.sv
// Constants shared by the ROM fetch patch unit
package rom_patch_pkg;
   localparam int          NUM_CH             = 4;
   localparam logic [11:0] OFS_ADDR_CH0       = 12'h0000;
   localparam logic [11:0] OFS_ADDR_CH1       = 12'h0004;
   localparam logic [11:0] OFS_ADDR_CH2       = 12'h0008;
   localparam logic [11:0] OFS_ADDR_CH3       = 12'h000C;
   localparam logic [11:0] OFS_ENABLES        = 12'h0010;
   localparam logic [31:0] RST_PATCH_ADDR     = 32'h0000_0000;
   localparam logic [3:0]  RST_ENABLES        = 4'h0;
   localparam logic [31:0] PATCH_ADDR_MASK    = 32'h000F_FFFE;
   localparam logic [31:0] TRAP_VECTOR        = 32'h0000_0060;
   localparam logic [31:0] RST_FETCH_DATA     = 32'h0000_0000;
   localparam int          ADDR_MSB           = 19;
   localparam int          ADDR_LSB           = 1;
endpackage : rom_patch_pkg

//--- rtl/rom_fetch_patch_unit.sv
// ROM fetch patch unit: four address comparators that swap ROM code for a trap
//
// Operation
// - Four independent channels, each with one patch address register.
// - Address registers take 32-bit words or separate 16-bit halves.
// - Address registers clear to zero on reset.
// - Bit 0 and bits 20 to 31 of each address read zero.
// - Control register holds one enable per channel; byte or bit access.
// - Control register clears on reset, all channels off.
// - A disabled channel never alters fetched code.
// - Enabled channel match replaces fetched code with the trap instruction.
// - Trap executes and the CPU branches to handler address 60h.
// - Data reads at a patched address also return the trap code.
`timescale 1ns/100ps
module rom_fetch_patch_unit
   import rom_patch_pkg::*;
#(
   parameter logic [31:0] TRAP_CODE = 32'h0000_0000  // Arbitrary default, set per core
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        fetch_valid,
   input  wire logic [31:0] fetch_addr,
   input  wire logic [31:0] rom_rdata,
   output logic             fetch_out_valid,
   output logic      [31:0] fetch_out_data,
   output logic             patch_hit,
   output logic      [3:0]  patch_hit_channel,
   output logic      [31:0] trap_vector
);

   logic [31:0] patch_address_register [NUM_CH];
   logic [3:0]  patch_control_register;
   logic [3:0]  next_hit;
   logic        setup_phase;
   logic        access_done;
   logic        wr_done;
   logic        addr_mapped;
   logic [31:0] next_rdata;

   // Registered pready gives every access exactly one access-phase cycle
   assign setup_phase = psel && !penable;
   assign access_done = psel && penable && pready;
   assign wr_done     = access_done && pwrite;

   // Address decode shared by read mux and error flag
   always_comb begin
      addr_mapped = 1'b1;
      next_rdata  = 32'h0000_0000;
      unique case (paddr)
         OFS_ADDR_CH0: next_rdata = patch_address_register[0];
         OFS_ADDR_CH1: next_rdata = patch_address_register[1];
         OFS_ADDR_CH2: next_rdata = patch_address_register[2];
         OFS_ADDR_CH3: next_rdata = patch_address_register[3];
         OFS_ENABLES:  next_rdata = {28'h000_0000, patch_control_register};
         default:      addr_mapped = 1'b0;
      endcase
   end

   // APB handshake and registered answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup_phase;
         pslverr <= setup_phase && !addr_mapped;
         if (setup_phase && !pwrite) begin
            prdata <= next_rdata;
         end
      end
   end

   // Address registers: byte lanes allow whole word or either 16-bit half
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
      logic [31:0] strb_mask;
      logic        sel;
      assign strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
      assign sel       = (paddr == OFS_ADDR_CH0 + 12'(4 * ch));
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            patch_address_register[ch] <= RST_PATCH_ADDR;
         end else if (wr_done && sel) begin
            // Fixed-zero bits are masked here so a read never shows them set
            patch_address_register[ch] <= ((pwdata & strb_mask) |
                                           (patch_address_register[ch] & ~strb_mask)) &
                                          PATCH_ADDR_MASK;
         end
      end
      // Comparator sees every ROM access, fetch or data alike
      assign next_hit[ch] = fetch_valid && patch_control_register[ch] &&
                            (fetch_addr[ADDR_MSB:ADDR_LSB] ==
                             patch_address_register[ch][ADDR_MSB:ADDR_LSB]);
   end

   // Enable register: low byte only; bit writes are read-modify-write by the CPU
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         patch_control_register <= RST_ENABLES;
      end else if (wr_done && (paddr == OFS_ENABLES) && pstrb[0]) begin
         patch_control_register <= pwdata[3:0];
      end
   end

   // One fixed pipeline stage; latency is constant so no wait state is added
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_out_valid   <= 1'b0;
         fetch_out_data    <= RST_FETCH_DATA;
         patch_hit         <= 1'b0;
         patch_hit_channel <= 4'h0;
      end else begin
         fetch_out_valid   <= fetch_valid;
         fetch_out_data    <= (|next_hit) ? TRAP_CODE : rom_rdata;
         patch_hit         <= |next_hit;
         patch_hit_channel <= next_hit;
      end
   end

   // Handler vector the core jumps to after the trap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_vector <= TRAP_VECTOR;
      end else begin
         trap_vector <= TRAP_VECTOR;
      end
   end

   // Checks
   AST_ADDR_ZERO_BITS: assert property (@(posedge pclk) disable iff (!presetn)
      (patch_address_register[0] & ~PATCH_ADDR_MASK) == 32'h0000_0000)
      else $error("Fixed-zero address bits set on channel 0");

   AST_HIT_SWAPS: assert property (@(posedge pclk) disable iff (!presetn)
      (|next_hit) |=> (fetch_out_data == TRAP_CODE) && patch_hit)
      else $error("Matched fetch not replaced by trap");

   AST_MISS_PASSES: assert property (@(posedge pclk) disable iff (!presetn)
      (fetch_valid && !(|next_hit)) |=> (fetch_out_data == $past(rom_rdata)) && !patch_hit)
      else $error("Unmatched fetch altered");

   AST_DISABLED_NO_HIT: assert property (@(posedge pclk) disable iff (!presetn)
      (!patch_control_register[1]) |=> !patch_hit_channel[1])
      else $error("Disabled channel 1 reported a hit");

   AST_FETCH_LATENCY: assert property (@(posedge pclk) disable iff (!presetn)
      fetch_valid |=> fetch_out_valid)
      else $error("Fetch result not one cycle later");

   AST_ADDR_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && paddr == OFS_ADDR_CH2 && pstrb == 4'b1111) |=>
      patch_address_register[2] == ($past(pwdata) & PATCH_ADDR_MASK))
      else $error("Word write to channel 2 not stored");

   AST_HALF_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && paddr == OFS_ADDR_CH0 && pstrb == 4'b1100) |=>
      patch_address_register[0][15:0] == $past(patch_address_register[0][15:0]))
      else $error("Upper-half write disturbed lower half");

   AST_ENABLE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && paddr == OFS_ENABLES && pstrb[0]) |=> patch_control_register == $past(pwdata[3:0]))
      else $error("Enable write not stored");

   AST_RESET_CLEAR: assert property (@(posedge pclk)
      $rose(presetn) |-> patch_control_register == 4'h0 && patch_address_register[3] == 32'h0000_0000)
      else $error("Registers not cleared by reset");

   AST_PREADY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
      setup_phase |=> pready ##1 !pready)
      else $error("Access phase not exactly one cycle");

   AST_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)
      trap_vector == TRAP_VECTOR)
      else $error("Trap vector wrong");

   // Fixed-zero bits on the remaining channels
   AST_ADDR_ZERO_BITS_CH1: assert property (@(posedge pclk) disable iff (!presetn)
      (patch_address_register[1] & ~PATCH_ADDR_MASK) == 32'h0000_0000)
      else $error("Fixed-zero address bits set on channel 1");

   AST_ADDR_ZERO_BITS_CH2: assert property (@(posedge pclk) disable iff (!presetn)
      (patch_address_register[2] & ~PATCH_ADDR_MASK) == 32'h0000_0000)
      else $error("Fixed-zero address bits set on channel 2");

   AST_ADDR_ZERO_BITS_CH3: assert property (@(posedge pclk) disable iff (!presetn)
      (patch_address_register[3] & ~PATCH_ADDR_MASK) == 32'h0000_0000)
      else $error("Fixed-zero address bits set on channel 3");

   // A disabled channel stays silent whatever the fetch address
   AST_DISABLED_NO_HIT_CH0: assert property (@(posedge pclk) disable iff (!presetn)
      (!patch_control_register[0]) |=> !patch_hit_channel[0])
      else $error("Disabled channel 0 reported a hit");

   AST_DISABLED_NO_HIT_CH2: assert property (@(posedge pclk) disable iff (!presetn)
      (!patch_control_register[2]) |=> !patch_hit_channel[2])
      else $error("Disabled channel 2 reported a hit");

   AST_DISABLED_NO_HIT_CH3: assert property (@(posedge pclk) disable iff (!presetn)
      (!patch_control_register[3]) |=> !patch_hit_channel[3])
      else $error("Disabled channel 3 reported a hit");

   // Each enabled channel that matches must trap on the very next cycle
   AST_MATCH_CH0: assert property (@(posedge pclk) disable iff (!presetn)
      (fetch_valid && patch_control_register[0] &&
       (fetch_addr[ADDR_MSB:ADDR_LSB] == patch_address_register[0][ADDR_MSB:ADDR_LSB])) |=>
      patch_hit_channel[0] && (fetch_out_data == TRAP_CODE))
      else $error("Channel 0 match not trapped");

   AST_MATCH_CH1: assert property (@(posedge pclk) disable iff (!presetn)
      (fetch_valid && patch_control_register[1] &&
       (fetch_addr[ADDR_MSB:ADDR_LSB] == patch_address_register[1][ADDR_MSB:ADDR_LSB])) |=>
      patch_hit_channel[1] && (fetch_out_data == TRAP_CODE))
      else $error("Channel 1 match not trapped");

   AST_MATCH_CH2: assert property (@(posedge pclk) disable iff (!presetn)
      (fetch_valid && patch_control_register[2] &&
       (fetch_addr[ADDR_MSB:ADDR_LSB] == patch_address_register[2][ADDR_MSB:ADDR_LSB])) |=>
      patch_hit_channel[2] && (fetch_out_data == TRAP_CODE))
      else $error("Channel 2 match not trapped");

   AST_MATCH_CH3: assert property (@(posedge pclk) disable iff (!presetn)
      (fetch_valid && patch_control_register[3] &&
       (fetch_addr[ADDR_MSB:ADDR_LSB] == patch_address_register[3][ADDR_MSB:ADDR_LSB])) |=>
      patch_hit_channel[3] && (fetch_out_data == TRAP_CODE))
      else $error("Channel 3 match not trapped");

   // Summary flag agrees with the per-channel hits
   AST_HIT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      patch_hit == (|patch_hit_channel))
      else $error("Hit flag disagrees with channel hits");

   // No access in, no result out
   AST_NO_FETCH_NO_HIT: assert property (@(posedge pclk) disable iff (!presetn)
      !fetch_valid |=> !fetch_out_valid && !patch_hit)
      else $error("Result without a fetch");

   // Error response only ever rides on pready
   AST_PSLVERR_WITH_PREADY: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("Error response without pready");

   // Decode decides the response of every access
   AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_phase && !addr_mapped) |=> pslverr)
      else $error("Unmapped access not refused");

   AST_MAPPED_OK: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_phase && addr_mapped) |=> !pslverr)
      else $error("Mapped access refused");

   // Read data is the register value at the setup edge
   AST_READ_DATA: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_phase && !pwrite && paddr == OFS_ADDR_CH1) |=>
      prdata == $past(patch_address_register[1]))
      else $error("Channel 1 read data wrong");

   AST_READ_ENABLES: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_phase && !pwrite && paddr == OFS_ENABLES) |=> prdata[31:4] == 28'h000_0000)
      else $error("Unused enable bits read set");

   // Lower-half write keeps the upper half and drops bit 0
   AST_LOWER_HALF_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && paddr == OFS_ADDR_CH0 && pstrb == 4'b0011) |=>
      (patch_address_register[0][31:16] == $past(patch_address_register[0][31:16])) &&
      (patch_address_register[0][15:0] == ($past(pwdata[15:0]) & PATCH_ADDR_MASK[15:0])))
      else $error("Lower-half write to channel 0 wrong");

   // Writes with no byte lane set leave the registers unchanged; pslverr still follows the address decode
   AST_NO_STRB_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && pstrb == 4'h0) |=>
      $stable(patch_address_register[3]) && $stable(patch_control_register))
      else $error("Write without byte lanes changed a register");

   // Registers move only on their own write; reads never disturb them
   AST_ENABLE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_done && paddr == OFS_ENABLES && pstrb[0]) |=> $stable(patch_control_register))
      else $error("Enable register changed without a write");

   AST_ADDR_HOLD_CH0: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_done && paddr == OFS_ADDR_CH0) |=> $stable(patch_address_register[0]))
      else $error("Channel 0 address changed without a write");

   // Reset clears every register and handshake output except trap_vector, which reset loads with 60h
   AST_RESET_ADDR: assert property (@(posedge pclk)
      $rose(presetn) |-> (patch_address_register[0] == RST_PATCH_ADDR) &&
      (patch_address_register[1] == RST_PATCH_ADDR) && (patch_address_register[2] == RST_PATCH_ADDR))
      else $error("Address registers not cleared by reset");

   AST_RESET_OUTPUTS: assert property (@(posedge pclk)
      $rose(presetn) |-> !pready && !pslverr && !fetch_out_valid && !patch_hit)
      else $error("Outputs not cleared by reset");

   COV_HIT:       cover property (@(posedge pclk) disable iff (!presetn) |next_hit);
   COV_MULTI_HIT: cover property (@(posedge pclk) disable iff (!presetn) next_hit[0] && next_hit[3]);
   COV_BAD_ADDR:  cover property (@(posedge pclk) disable iff (!presetn) access_done && pslverr);
   COV_HALF_WR:   cover property (@(posedge pclk) disable iff (!presetn) wr_done && pstrb == 4'b0011);
   COV_B2B_FETCH: cover property (@(posedge pclk) disable iff (!presetn) fetch_valid ##1 fetch_valid);

endmodule : rom_fetch_patch_unit

//--- tb/rom_model.sv
// CPU fetch side model: supplies ROM words for the fetch addresses it sees
`timescale 1ns/100ps
module rom_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        fetch_valid,
   input  wire logic [31:0] fetch_addr,
   output logic      [31:0] rom_rdata
);
   logic [31:0] last;
   // Idle bus shows the inverse of the last word fetched, so stale data never looks valid
   always_comb rom_rdata = fetch_valid ? {fetch_addr[15:0], ~fetch_addr[15:0]} : ~last;
   // Only real accesses update the remembered word; idle cycles must not toggle it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last <= 32'h0000_0000;
      end else if (fetch_valid) begin
         last <= rom_rdata;
      end
   end
endmodule : rom_model

//--- tb/rom_fetch_patch_unit_test.sv
// Self-checking bench for the ROM fetch patch unit
`timescale 1ns/100ps
module rom_fetch_patch_unit_test;
   import rom_patch_pkg::*;
   localparam logic [31:0] TRAP = 32'h5A5A_0F0F;  // Arbitrary trap code
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fetch_valid, fetch_out_valid, patch_hit;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, fetch_addr, rom_rdata, fetch_out_data, trap_vector;
   logic [3:0]  pstrb, patch_hit_channel;
   logic [31:0] ch_addr [4];
   logic [32:0] rq [$];
   logic [36:0] fq [$];
   int error_cnt, n_tests, cyc;
   rom_fetch_patch_unit #(.TRAP_CODE(TRAP)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
      .rom_rdata(rom_rdata), .fetch_out_valid(fetch_out_valid), .fetch_out_data(fetch_out_data),
      .patch_hit(patch_hit), .patch_hit_channel(patch_hit_channel), .trap_vector(trap_vector));
   rom_model rom_u (.pclk(pclk), .presetn(presetn), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
      .rom_rdata(rom_rdata));
   initial begin
      pclk = 0;
      forever #2 pclk = ~pclk;
   end
   task chk(input string nm, input logic [36:0] got, input logic [36:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task conclude;
      if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // One APB transfer; an edge passes first so psel is never assigned twice in one step
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 0; penable <= 0;
   endtask : apb
   task rd(input logic [11:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(0, a, 32'h0000_0000, 4'hF);
   endtask : rd
   // Fetch for one cycle; the expected word follows the model's ROM pattern
   task fetch(input logic [31:0] a, input logic [3:0] en);
      logic [3:0]  h;
      logic [31:0] saved_pc;
      // Handler view: the saved PC points past the trap, so the channel sits at PC minus 2
      saved_pc = a + 32'h0000_0002;
      for (int i = 0; i < 4; i++) h[i] = en[i] && (ch_addr[i] == saved_pc - 32'h0000_0002);
      fq.push_back({|h, h, (|h) ? TRAP : {a[15:0], ~a[15:0]}});
      fetch_valid <= 1; fetch_addr <= a;
      @(posedge pclk);
   endtask : fetch
   // Results are matched against the oldest note as they appear
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 5000) begin
         error_cnt++;
         conclude();
      end else begin
         if (psel && penable && pready && !pwrite) begin
            chk("apb read", {pslverr, prdata}, rq.pop_front());
         end
         if (fetch_out_valid) begin
            chk("fetch", {patch_hit, patch_hit_channel, fetch_out_data}, fq.pop_front());
         end
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, fetch_valid} = 0;
      {paddr, pwdata, fetch_addr, pstrb} = 0;
      void'($urandom(32'h674f));
      repeat (20) @(posedge pclk);
      presetn <= 1;
      chk("vector", trap_vector, TRAP_VECTOR);
      for (int i = 0; i < 5; i++) rd(12'(4 * i), 33'h0_0000_0000);
      rd(12'h0FFC, 33'h1_0000_0000);
      apb(1, OFS_ADDR_CH0, 32'hFFFF_FFFF, 4'hF);
      rd(OFS_ADDR_CH0, {1'b0, PATCH_ADDR_MASK});
      apb(1, OFS_ADDR_CH0, 32'h0000_0000, 4'h3);
      rd(OFS_ADDR_CH0, 33'h0_000F_0000);
      apb(1, OFS_ADDR_CH0, 32'h0000_0000, 4'hC);
      rd(OFS_ADDR_CH0, 33'h0_0000_0000);
      apb(1, OFS_ADDR_CH1, 32'hFFFF_FFFF, 4'h2);
      rd(OFS_ADDR_CH1, 33'h0_0000_FF00);
      apb(1, OFS_ENABLES, 32'hFFFF_FFFF, 4'hF);
      rd(OFS_ENABLES, 33'h0_0000_000F);
      apb(1, OFS_ENABLES, 32'h0000_0000, 4'h0);
      rd(OFS_ENABLES, 33'h0_0000_000F);
      // Distinct addresses inside the ROM range, upper bits cleared
      for (int i = 0; i < 4; i++) begin
         ch_addr[i] = ($urandom & 32'h0000_FFFE) | (i << 16);
         apb(1, 12'(4 * i), ch_addr[i], 4'hF);
      end
      // Every enable mask: trap, idle handler time, then the return fetch as a near miss
      for (int m = 0; m < 16; m++) begin
         apb(1, OFS_ENABLES, 32'(m), 4'h1);
         for (int i = 0; i < 4; i++) begin
            fetch(ch_addr[i], 4'(m));
            // Handler and replacement code run from RAM, so the ROM sees no access
            fetch_valid <= 0;
            @(posedge pclk);
            fetch(ch_addr[i] + 32'h0000_0002, 4'(m)); // Resume past the trap
         end
         fetch_valid <= 0;
      end
      repeat (4) @(posedge pclk);
      // Mid-run reset must clear every register written above
      presetn <= 0;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      for (int i = 0; i < 5; i++) rd(12'(4 * i), 33'h0_0000_0000);
      repeat (4) @(posedge pclk);
      chk("queues", 37'(fq.size() + rq.size()), 37'h0);
      conclude();
   end
endmodule : rom_fetch_patch_unit_test
